// file: common/rsc_map.vh
// Constants for the reset and stop-recovery controller.
// Assumes a 50 MHz system clock and one synchronous reset.
//
// Contract
// - Reset on POR, brown-out, watchdog, pin, debugger.
// - Stop recovery on watchdog or enabled pin edge.
// - Hold 66 oscillator cycles, 5000 with crystal.
// - Wait 4 us oscillator start before counting.
// - Supply reset counts only after supply good.
// - Pin still low at expiry keeps reset.
// - Reset makes pins inputs, pull-ups off.
// - Reset pin driven low during port reset; the code lets go of it while waiting for the pin, with port_reset still high.
// - CPU and peripherals idle, oscillators keep running.
// - Control registers load reset values on reset.
// - CPU fetches vector at 0002H and 0003H.
// - System reset selects internal oscillator as clock.
// - Ignore pin pulses under three clocks when awake.
// - Debugger reset leaves the debugger untouched; the code treats it as POR and asserts debugger_reset_clear.
// - Stop mode: filtered pin, debug pin resets.
// - Hold reset until supply good and counter done.
// - Power-on reset sets the power-on status bit.
// - Brown-out forces reset, then full reset sequence.
// - Brown-out in stop follows its option bit.
// - Watchdog resets if select is 1, else interrupt.
// - Watchdog reset sets the watchdog status bit.
// - Stop recovery changes only watchdog, oscillator regs.
// - Reading status clears its upper four bits.
// - Pin reset sets the external-reset status bit.
// - Internal reset drives pin low through hold.
`ifndef RSC_MAP_VH
`define RSC_MAP_VH
`define RSC_HOLD_SHORT     66
`define RSC_HOLD_XTAL      5000
`define RSC_OSC_START_NS   4000
`define RSC_CLK_PERIOD_NS  20
`define RSC_OSC_START_CYC  ((`RSC_OSC_START_NS + `RSC_CLK_PERIOD_NS - 1) \
                            / `RSC_CLK_PERIOD_NS)
`define RSC_PIN_FILT_AWAKE 3
`define RSC_PIN_FILT_STOP  8
`define RSC_VECTOR_HI      16'h0002
`define RSC_VECTOR_LO      16'h0003
`define RSC_STAT_POR       7
`define RSC_STAT_STOP      6
`define RSC_STAT_WDT       5
`define RSC_STAT_EXT       4
`define RSC_OSCCTL_RESET   8'hA0
`endif

// file: design/rsc_reset_stop_recovery_controller.v
// Reset and stop-mode recovery sequencer with reset-cause status.
// Assumes analog detectors, watchdog and stop entry are driven from
// outside on clk; the pin and debug pin are asynchronous.
`timescale 1ns/1ps
`include "rsc_map.vh"

module rsc_reset_stop_recovery_controller #(
  parameter HOLD_XTAL   = `RSC_HOLD_XTAL,
  parameter HOLD_SHORT  = `RSC_HOLD_SHORT,
  parameter OSC_START   = `RSC_OSC_START_CYC,
  parameter FILT_STOP   = `RSC_PIN_FILT_STOP,
  parameter GPIO_WIDTH  = 8
) (
  input  wire                  clk,
  input  wire                  srst,
  input  wire                  supply_above_por,
  input  wire                  brownout_detect,
  input  wire                  watchdog_timeout,
  input  wire                  watchdog_reset_select_option,
  input  wire                  brownout_in_stop_option,
  input  wire                  xtal_enable_option,
  input  wire                  pin_reset_enable,
  input  wire                  debugger_reset_request,
  input  wire                  stop_mode,
  input  wire [GPIO_WIDTH-1:0] gpio_in,
  input  wire [GPIO_WIDTH-1:0] gpio_recovery_enable,
  input  wire                  port_d_bit0_reset_pin_in,
  input  wire                  debug_pin,
  input  wire                  status_read,
  output wire                  port_d_bit0_reset_pin_out,
  output wire                  port_d_bit0_reset_pin_oe,
  output reg                   cpu_reset,
  output reg                   periph_reset,
  output reg                   port_reset,
  output wire                  debugger_reset_clear,
  output reg                   watchdog_interrupt,
  output reg                   clk_select_internal_osc,
  output reg                   watchdog_ctrl_reload,
  output reg                   oscillator_ctrl_reload,
  output reg                   control_reg_reload,
  output reg  [7:0]            oscillator_control_reg,
  output reg  [7:0]            reset_cause_status_reg,
  output reg  [15:0]           vector_fetch_addr,
  output reg                   vector_fetch_valid
);

  // ****************************************************************
  // Sequencer states
  // ****************************************************************
  localparam ST_RUN   = 5'b00001;
  localparam ST_SUPW  = 5'b00010;
  localparam ST_OSC   = 5'b00100;
  localparam ST_HOLD  = 5'b01000;
  localparam ST_PIN   = 5'b10000;

  localparam [1:0] CAUSE_POR = 2'd0;
  localparam [1:0] CAUSE_EXT = 2'd1;
  localparam [1:0] CAUSE_WDT = 2'd2;
  localparam [1:0] CAUSE_SMR = 2'd3;
  localparam [7:0] FILT_AWAKE = `RSC_PIN_FILT_AWAKE;

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  reg                  pin_meta_reg;
  reg                  pin_sync_reg;
  reg                  dbg_meta_reg;
  reg                  dbg_sync_reg;
  reg [GPIO_WIDTH-1:0] gpio_meta_reg;
  reg [GPIO_WIDTH-1:0] gpio_sync_reg;
  reg [GPIO_WIDTH-1:0] gpio_prev_reg;

  always @(posedge clk) begin
    if (srst) begin
      pin_meta_reg  <= 1'b1;
      pin_sync_reg  <= 1'b1;
      dbg_meta_reg  <= 1'b1;
      dbg_sync_reg  <= 1'b1;
      gpio_meta_reg <= {GPIO_WIDTH{1'b0}};
      gpio_sync_reg <= {GPIO_WIDTH{1'b0}};
      gpio_prev_reg <= {GPIO_WIDTH{1'b0}};
    end else begin
      pin_meta_reg  <= port_d_bit0_reset_pin_in;
      pin_sync_reg  <= pin_meta_reg;
      dbg_meta_reg  <= debug_pin;
      dbg_sync_reg  <= dbg_meta_reg;
      gpio_meta_reg <= gpio_in;
      gpio_sync_reg <= gpio_meta_reg;
      gpio_prev_reg <= gpio_sync_reg;
    end
  end

  // ****************************************************************
  // Reset pin pulse filter
  // ****************************************************************
  reg  [7:0] filt_cnt_reg;
  wire [7:0] filt_limit;
  wire       pin_low_filtered;

  // Stop mode uses the longer filter; awake mode three clocks.
  assign filt_limit = stop_mode ? FILT_STOP[7:0] :
                      FILT_AWAKE;
  assign pin_low_filtered = (filt_cnt_reg >= filt_limit);

  always @(posedge clk) begin
    if (srst) begin
      filt_cnt_reg <= 8'h00;
    end else if (pin_sync_reg) begin
      filt_cnt_reg <= 8'h00;
    end else if (!pin_low_filtered) begin
      filt_cnt_reg <= filt_cnt_reg + 8'h01;
    end
  end

  // ****************************************************************
  // Source decode
  // ****************************************************************
  reg  state_reg;
  reg  smr_wdt_reg;
  reg  [4:0] st_reg;
  reg  [4:0] st_next;
  reg  [15:0] cnt_reg;
  reg  [15:0] cnt_next;
  reg  [1:0] cause_reg;
  reg  [1:0] cause_next;
  wire       running;
  wire       bo_active;
  wire       wdt_reset_req;
  wire       pin_req;
  wire       dbg_req;
  wire       supply_req;
  wire       smr_req;
  wire [15:0] hold_len;

  assign running = (st_reg == ST_RUN);
  assign bo_active = brownout_detect &
                     (!stop_mode | brownout_in_stop_option);
  assign supply_req = !supply_above_por | bo_active;
  assign wdt_reset_req = watchdog_timeout &
                         watchdog_reset_select_option;
  assign pin_req = pin_reset_enable & pin_low_filtered;
  assign dbg_req = debugger_reset_request |
                   (stop_mode & !dbg_sync_reg);
  assign smr_req = stop_mode & (watchdog_timeout |
                   (|((gpio_sync_reg ^ gpio_prev_reg) &
                      gpio_recovery_enable)));
  assign hold_len = xtal_enable_option ? HOLD_XTAL[15:0] :
                    HOLD_SHORT[15:0];
  assign debugger_reset_clear = (st_reg == ST_OSC) & (cause_reg == CAUSE_POR);

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always @* begin
    st_next    = st_reg;
    cnt_next   = cnt_reg;
    cause_next = cause_reg;
    if (supply_req) begin
      st_next    = ST_SUPW;
      cause_next = CAUSE_POR;
      cnt_next   = 16'h0000;
    end else begin
      case (st_reg)
        ST_RUN: begin
          cnt_next = 16'h0000;
          if (dbg_req) begin
            st_next    = ST_OSC;
            cause_next = CAUSE_POR;
          end else if (pin_req) begin
            st_next    = ST_OSC;
            cause_next = CAUSE_EXT;
          end else if (wdt_reset_req && !stop_mode) begin
            st_next    = ST_OSC;
            cause_next = CAUSE_WDT;
          end else if (smr_req) begin
            st_next    = ST_OSC;
            cause_next = CAUSE_SMR;
          end
        end
        ST_SUPW: begin
          st_next  = ST_OSC;
          cnt_next = 16'h0000;
        end
        ST_OSC: begin
          if (cnt_reg >= OSC_START[15:0] - 16'h0001) begin
            st_next  = ST_HOLD;
            cnt_next = 16'h0000;
          end else begin
            cnt_next = cnt_reg + 16'h0001;
          end
        end
        ST_HOLD: begin
          if (cnt_reg >= hold_len - 16'h0001) begin
            st_next  = pin_sync_reg ? ST_RUN : ST_PIN;
            cnt_next = 16'h0000;
          end else begin
            cnt_next = cnt_reg + 16'h0001;
          end
        end
        ST_PIN: begin
          if (pin_sync_reg) begin
            st_next = ST_RUN;
          end
        end
        default: begin
          st_next = ST_SUPW;
        end
      endcase
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      st_reg    <= ST_SUPW;
      cnt_reg   <= 16'h0000;
      cause_reg <= CAUSE_POR;
    end else begin
      st_reg    <= st_next;
      cnt_reg   <= cnt_next;
      cause_reg <= cause_next;
    end
  end

  // ****************************************************************
  // Reset outputs and pin driver
  // ****************************************************************
  wire in_reset;
  wire sys_reset;
  wire start_seq;

  assign in_reset  = !(st_next == ST_RUN);
  assign sys_reset = (cause_reg != CAUSE_SMR);
  assign start_seq = running & !(st_next == ST_RUN);
  // Open-drain: drive low only, and let go while waiting for the pin,
  // since the pin would otherwise read back its own drive for ever.
  assign port_d_bit0_reset_pin_out = 1'b0;
  assign port_d_bit0_reset_pin_oe  = !running & sys_reset &
                                     (st_reg != ST_PIN);

  always @(posedge clk) begin
    if (srst) begin
      cpu_reset               <= 1'b1;
      periph_reset            <= 1'b1;
      port_reset              <= 1'b1;
      watchdog_interrupt      <= 1'b0;
      clk_select_internal_osc <= 1'b1;
      watchdog_ctrl_reload    <= 1'b0;
      oscillator_ctrl_reload  <= 1'b0;
      control_reg_reload      <= 1'b0;
      oscillator_control_reg  <= `RSC_OSCCTL_RESET;
      vector_fetch_addr       <= 16'h0000;
      vector_fetch_valid      <= 1'b0;
      state_reg               <= 1'b0;
      smr_wdt_reg             <= 1'b0;
    end else begin
      cpu_reset    <= in_reset;
      periph_reset <= in_reset & (cause_next != CAUSE_SMR);
      port_reset   <= in_reset & (cause_next != CAUSE_SMR);
      watchdog_interrupt <= watchdog_timeout &
                            !watchdog_reset_select_option;
      watchdog_ctrl_reload   <= start_seq;
      oscillator_ctrl_reload <= start_seq;
      control_reg_reload     <= start_seq &
                                (cause_next != CAUSE_SMR);
      if (start_seq) begin
        clk_select_internal_osc <= 1'b1;
        oscillator_control_reg  <= `RSC_OSCCTL_RESET;
        smr_wdt_reg             <= watchdog_timeout;
      end
      // Two-cycle vector fetch after reset release.
      vector_fetch_valid <= 1'b0;
      state_reg          <= 1'b0;
      if (!running && st_next == ST_RUN) begin
        vector_fetch_addr  <= `RSC_VECTOR_HI;
        vector_fetch_valid <= 1'b1;
        state_reg          <= 1'b1;
      end else if (state_reg) begin
        vector_fetch_addr  <= `RSC_VECTOR_LO;
        vector_fetch_valid <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Reset cause status
  // ****************************************************************
  reg [3:0] cause_bits;

  always @* begin
    cause_bits = 4'h0;
    case (cause_reg)
      CAUSE_POR: cause_bits = 4'h8;
      CAUSE_EXT: cause_bits = 4'h1;
      CAUSE_WDT: cause_bits = 4'h2;
      CAUSE_SMR: cause_bits = smr_wdt_reg ? 4'h6 : 4'h4;
      default:   cause_bits = 4'h0;
    endcase
  end

  // A new cause latched in the same cycle as a read wins over the clear.
  always @(posedge clk) begin
    if (srst) begin
      reset_cause_status_reg <= 8'h80;
    end else if (start_seq) begin
      reset_cause_status_reg <= 8'h00;
    end else if (!running && st_next == ST_RUN) begin
      reset_cause_status_reg <= {cause_bits, 4'h0};
    end else if (status_read && running) begin
      reset_cause_status_reg <= 8'h00;
    end
  end

endmodule // rsc_reset_stop_recovery_controller

// file: verification/rsc_monitor.sv
// Port assertions for the reset and stop-recovery controller.
// Assumes a bind to the controller, handing on its count parameters.
`timescale 1ns/1ps
module rsc_monitor #(
  parameter HOLD_XTAL  = 5000,
  parameter HOLD_SHORT = 66,
  parameter OSC_START  = 200
) (
  input wire        clk,
  input wire        srst,
  input wire        supply_above_por,
  input wire        watchdog_timeout,
  input wire        watchdog_reset_select_option,
  input wire        xtal_enable_option,
  input wire        pin_reset_enable,
  input wire        stop_mode,
  input wire        port_d_bit0_reset_pin_in,
  input wire        status_read,
  input wire        port_d_bit0_reset_pin_oe,
  input wire        cpu_reset,
  input wire        port_reset,
  input wire [7:0]  reset_cause_status_reg,
  input wire [15:0] vector_fetch_addr,
  input wire        vector_fetch_valid
);
  // ******************************************************************
  // Reset length counter and checks
  // ******************************************************************
  // Counts reset cycles since the supply was last good.
  reg [15:0] held_reg;
  always @(posedge clk) begin
    if (srst || !cpu_reset || !supply_above_por)
      held_reg <= 16'h0000;
    else
      held_reg <= held_reg + 16'h0001;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  chk_wdt_resets: assert property (
    !cpu_reset && watchdog_timeout && watchdog_reset_select_option
    |=> cpu_reset) else $error("watchdog reset missing");
  chk_supply_loss: assert property (
    !supply_above_por |=> cpu_reset) else $error("supply loss ignored");
  chk_hold_len: assert property (
    $fell(cpu_reset) |-> held_reg >= OSC_START +
    (xtal_enable_option ? HOLD_XTAL : HOLD_SHORT))
    else $error("reset hold too short");
  chk_pin_holds: assert property (
    cpu_reset && pin_reset_enable && !port_d_bit0_reset_pin_in &&
    !port_d_bit0_reset_pin_oe |=> cpu_reset) else $error("pin hold lost");
  chk_oe_drive: assert property (
    $rose(port_reset) |-> ##[0:2] port_d_bit0_reset_pin_oe)
    else $error("reset pin not driven");
  chk_stop_recov: assert property (
    !cpu_reset && stop_mode && watchdog_timeout && supply_above_por &&
    port_d_bit0_reset_pin_in |=> cpu_reset && !port_reset)
    else $error("stop recovery wrong");
  chk_status_clear: assert property (
    status_read && !cpu_reset |=> reset_cause_status_reg == 8'h00)
    else $error("status not cleared");
  chk_vector_order: assert property (
    $fell(cpu_reset) |-> ##[0:1] (vector_fetch_valid &&
    vector_fetch_addr == 16'h0002) ##1 (vector_fetch_valid &&
    vector_fetch_addr == 16'h0003)) else $error("vector fetch wrong");
endmodule // rsc_monitor

// file: verification/rsc_board_model.sv
// Board side of the shared reset pin with its pull-up.
// Assumes the controller drives the pin only through its enable.
`timescale 1ns/1ps
module rsc_board_model (
  input  wire pin_oe,
  input  wire pin_out,
  input  wire board_low,
  output wire pin
);
  assign pin = ((pin_oe && !pin_out) || board_low) ? 1'b0 : 1'b1;
endmodule // rsc_board_model

// file: verification/rsc_reset_stop_recovery_controller_bench.sv
// Self-checking bench for the reset and stop-recovery controller.
// Assumes shortened hold counts and a board model on the reset pin.
`timescale 1ns/1ps
module rsc_reset_stop_recovery_controller_bench;
  localparam OSC_S = 10, HOLD_S = 12, HOLD_X = 20;
  reg  clk = 1'b0, srst = 1'b1, supply_above_por = 1'b1;
  reg  brownout_detect = 1'b0, watchdog_timeout = 1'b0, stop_mode = 1'b0;
  reg  watchdog_reset_select_option = 1'b1, xtal_enable_option = 1'b0;
  reg  pin_reset_enable = 1'b1, debugger_reset_request = 1'b0;
  reg  debug_pin = 1'b1, status_read = 1'b0, board_low = 1'b0;
  reg  brownout_in_stop_option = 1'b0;
  reg  [7:0] gpio_in = 8'h00, gpio_recovery_enable = 8'h01;
  wire port_d_bit0_reset_pin_in, port_d_bit0_reset_pin_out, cpu_reset;
  wire port_d_bit0_reset_pin_oe, periph_reset, port_reset, watchdog_interrupt;
  wire debugger_reset_clear, clk_select_internal_osc, control_reg_reload;
  wire watchdog_ctrl_reload, oscillator_ctrl_reload, vector_fetch_valid;
  wire [7:0]  oscillator_control_reg, reset_cause_status_reg;
  wire [15:0] vector_fetch_addr;
  integer n_mismatch = 0, num_checks = 0, seed = 79, i, n;
  rsc_reset_stop_recovery_controller #(
    .HOLD_XTAL(HOLD_X), .HOLD_SHORT(HOLD_S), .OSC_START(OSC_S)
  ) u_dut (
    .clk, .srst, .supply_above_por, .brownout_detect, .watchdog_timeout,
    .watchdog_reset_select_option, .brownout_in_stop_option,
    .xtal_enable_option, .pin_reset_enable, .debugger_reset_request,
    .stop_mode, .gpio_in, .gpio_recovery_enable, .port_d_bit0_reset_pin_in,
    .debug_pin, .status_read, .port_d_bit0_reset_pin_out,
    .port_d_bit0_reset_pin_oe, .cpu_reset, .periph_reset, .port_reset,
    .debugger_reset_clear, .watchdog_interrupt, .clk_select_internal_osc,
    .watchdog_ctrl_reload, .oscillator_ctrl_reload, .control_reg_reload,
    .oscillator_control_reg, .reset_cause_status_reg, .vector_fetch_addr,
    .vector_fetch_valid
  );
  rsc_board_model u_board (.pin_oe(port_d_bit0_reset_pin_oe),
    .pin_out(port_d_bit0_reset_pin_out), .board_low(board_low),
    .pin(port_d_bit0_reset_pin_in));
  initial begin
    forever #10 clk = ~clk;
  end
  initial begin
    #400000;
    n_mismatch = n_mismatch + 1;
    wrap_up;
  end
  // ******************************************************************
  // Checking and sequencing tasks
  // ******************************************************************
  task check(input string what, input [15:0] exp, input [15:0] got);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Status expected after each cause of the run table.
  function [7:0] exp_stat(input integer c);
    case (c)
      0: exp_stat = 8'h20;
      2: exp_stat = 8'h10;
      3: exp_stat = 8'h60;
      4: exp_stat = 8'h40;
      default: exp_stat = 8'h80;
    endcase
  endfunction
  task wait_cpu(input v, input integer lim);
    n = 0;
    while (cpu_reset !== v && n < lim) begin
      @(negedge clk);
      n = n + 1;
    end
    check("cpu_reset", v, cpu_reset);
  endtask
  task run(input integer c);
    @(posedge clk);
    case (c)
      0, 3: watchdog_timeout <= 1'b1;
      1: debugger_reset_request <= 1'b1;
      2: board_low <= 1'b1;
      4: gpio_in <= gpio_in ^ gpio_recovery_enable;
      5: debug_pin <= 1'b0;
      default: supply_above_por <= 1'b0;
    endcase
    stop_mode <= (c >= 3 && c <= 5);
    brownout_detect <= (c == 6);
    wait_cpu(1'b1, 40);
    check("port_reset", (c != 3 && c != 4), port_reset);
    check("clk_sel", 1, clk_select_internal_osc);
    check("periph_reset", (c != 3 && c != 4), periph_reset);
    check("ctl reload", (c != 3 && c != 4), control_reg_reload);
    check("wdt reload", 1, watchdog_ctrl_reload);
    check("osc reload", 1, oscillator_ctrl_reload);
    check("pin drive", (c != 3 && c != 4), port_d_bit0_reset_pin_oe);
    check("pin level", 0, port_d_bit0_reset_pin_out);
    check("dbg clear", (c == 1 || c == 5), debugger_reset_clear);
    @(posedge clk);
    watchdog_timeout <= 1'b0;
    debugger_reset_request <= 1'b0;
    stop_mode <= 1'b0;
    debug_pin <= 1'b1;
    brownout_detect <= 1'b0;
    if (c == 2) begin
      repeat (40) @(negedge clk);
      check("pin hold", 1, cpu_reset);
      @(posedge clk);
      board_low <= 1'b0;
    end
    if (c == 6) begin
      repeat (5) @(posedge clk);
      supply_above_por <= 1'b1;
    end
    wait_cpu(1'b0, 6000);
    check("vec hi", 16'h0002, vector_fetch_addr);
    check("vec valid", 1, vector_fetch_valid);
    @(negedge clk);
    check("vec lo", 16'h0003, vector_fetch_addr);
    @(negedge clk);
    check("status", exp_stat(c), reset_cause_status_reg);
    @(posedge clk) status_read <= 1'b1;
    @(posedge clk) status_read <= 1'b0;
    @(negedge clk);
    check("status read", 8'h00, reset_cause_status_reg);
  endtask
  task wrap_up;
    if (n_mismatch == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    gpio_in <= $random(seed);
    gpio_recovery_enable <= $random(seed) | 8'h01;
    wait_cpu(1'b0, 400);
    repeat (2) @(negedge clk);
    check("status", 8'h80, reset_cause_status_reg);
    check("oscillator_control_reg", 8'hA0, oscillator_control_reg);
    for (i = 0; i < 7; i = i + 1) run(i);
    @(posedge clk) xtal_enable_option <= 1'b1;
    run(1);
    check("xtal hold", 1, n >= OSC_S + HOLD_X - 2);
    @(posedge clk) xtal_enable_option <= 1'b0;
    for (i = 0; i < 4; i = i + 1) begin
      @(posedge clk) board_low <= 1'b1;
      repeat (1 + ($random(seed) & 1)) @(posedge clk);
      board_low <= 1'b0;
      repeat (10) @(negedge clk);
      check("short pulse", 0, cpu_reset);
    end
    @(posedge clk) watchdog_reset_select_option <= 1'b0;
    @(posedge clk) watchdog_timeout <= 1'b1;
    @(posedge clk) watchdog_timeout <= 1'b0;
    @(negedge clk);
    check("wdt irq", 1, watchdog_interrupt);
    check("wdt no reset", 0, cpu_reset);
    // Brown-out in stop mode is ignored until its option bit is set.
    @(posedge clk);
    stop_mode       <= 1'b1;
    brownout_detect <= 1'b1;
    repeat (6) @(negedge clk);
    check("bo in stop", 0, cpu_reset);
    @(posedge clk) brownout_in_stop_option <= 1'b1;
    wait_cpu(1'b1, 4);
    @(posedge clk);
    stop_mode       <= 1'b0;
    brownout_detect <= 1'b0;
    wait_cpu(1'b0, 6000);
    repeat (2) @(negedge clk);
    check("status", 8'h80, reset_cause_status_reg);
    wrap_up;
  end
endmodule // rsc_reset_stop_recovery_controller_bench

bind rsc_reset_stop_recovery_controller rsc_monitor #(
  .HOLD_XTAL(HOLD_XTAL), .HOLD_SHORT(HOLD_SHORT), .OSC_START(OSC_START)
) u_mon (.clk, .srst, .supply_above_por, .watchdog_timeout,
  .watchdog_reset_select_option, .xtal_enable_option, .pin_reset_enable,
  .stop_mode, .port_d_bit0_reset_pin_in, .status_read,
  .port_d_bit0_reset_pin_oe, .cpu_reset, .port_reset,
  .reset_cause_status_reg, .vector_fetch_addr, .vector_fetch_valid);
